// file: src/srlct_top.v
// Purpose: Read latency code table for single-data-rate reads, plus the
//          read-phase sequencer that applies the selected row.
// Assumes: All inputs come from logic on clk; the serial front end reports
//          one sck_tick per serial clock cycle and a rd_stop at frame end.
// Notes:   Only the 50, 80 and 90 MHz rows are held; other bytes read FFh.
`timescale 1ns/10ps
`default_nettype none
`include "srlct_map.vh"

module srlct_top (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       qry_req,
   input  wire [6:0] qry_addr,
   output wire       qry_valid,
   output wire [7:0] qry_data,
   input  wire [1:0] lat_code,
   input  wire       rd_start,
   input  wire [7:0] rd_opcode,
   input  wire       sck_tick,
   input  wire       rd_stop,
   output wire       rd_mode_phase,
   output wire       rd_dummy_phase,
   output wire       rd_data_en,
   output wire       rd_reject,
   output wire       rd_four_byte,
   output wire [2:0] rd_instr
);

   // ========================================================================
   // Sequencer states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_MODE = 2'b01;
   localparam [1:0] ST_LAT  = 2'b10;
   localparam [1:0] ST_DATA = 2'b11;

   // ========================================================================
   // Lookup functions

   // Opcode stored at each position of the instruction list.
   function [7:0] op_of_pos;
      input [6:0] pos;
      begin
         case (pos[3:0])
            4'h0:    op_of_pos = `SRLCT_OP_RD3;
            4'h1:    op_of_pos = `SRLCT_OP_RD4;
            4'h2:    op_of_pos = `SRLCT_OP_FRD3;
            4'h3:    op_of_pos = `SRLCT_OP_FRD4;
            4'h4:    op_of_pos = `SRLCT_OP_DO3;
            4'h5:    op_of_pos = `SRLCT_OP_DO4;
            4'h6:    op_of_pos = `SRLCT_OP_QO3;
            4'h7:    op_of_pos = `SRLCT_OP_QO4;
            4'h8:    op_of_pos = `SRLCT_OP_DIO3;
            4'h9:    op_of_pos = `SRLCT_OP_DIO4;
            4'ha:    op_of_pos = `SRLCT_OP_QIO3;
            4'hb:    op_of_pos = `SRLCT_OP_QIO4;
            default: op_of_pos = `SRLCT_BLANK;
         endcase
      end
   endfunction

   // Decodes an opcode into {known, four address bytes, class}.
   function [4:0] decode_op;
      input [7:0] op;
      begin
         case (op)
            `SRLCT_OP_RD3:  decode_op = {2'b10, `SRLCT_I_RD};
            `SRLCT_OP_RD4:  decode_op = {2'b11, `SRLCT_I_RD};
            `SRLCT_OP_FRD3: decode_op = {2'b10, `SRLCT_I_FRD};
            `SRLCT_OP_FRD4: decode_op = {2'b11, `SRLCT_I_FRD};
            `SRLCT_OP_DO3:  decode_op = {2'b10, `SRLCT_I_DO};
            `SRLCT_OP_DO4:  decode_op = {2'b11, `SRLCT_I_DO};
            `SRLCT_OP_QO3:  decode_op = {2'b10, `SRLCT_I_QO};
            `SRLCT_OP_QO4:  decode_op = {2'b11, `SRLCT_I_QO};
            `SRLCT_OP_DIO3: decode_op = {2'b10, `SRLCT_I_DIO};
            `SRLCT_OP_DIO4: decode_op = {2'b11, `SRLCT_I_DIO};
            `SRLCT_OP_QIO3: decode_op = {2'b10, `SRLCT_I_QIO};
            `SRLCT_OP_QIO4: decode_op = {2'b11, `SRLCT_I_QIO};
            default:        decode_op = {2'b00, `SRLCT_I_RD};
         endcase
      end
   endfunction

   // Mode (lat=0) or latency (lat=1) cycles for a class under a code.
   // Both the query bytes and the sequencer use this, so the table the host
   // reads can never disagree with what the device actually does.
   function [7:0] cycles;
      input [1:0] code;
      input [2:0] cls;
      input       lat;
      begin
         cycles = `SRLCT_CYC_NA;
         case (code)
            `SRLCT_LC_50: begin
               case (cls)
                  `SRLCT_I_DIO: cycles = lat ? `SRLCT_CYC_0 : `SRLCT_CYC_4;
                  `SRLCT_I_QIO: cycles = lat ? `SRLCT_CYC_1 : `SRLCT_CYC_2;
                  default:      cycles = `SRLCT_CYC_0;
               endcase
            end
            `SRLCT_LC_80: begin
               case (cls)
                  `SRLCT_I_RD:  cycles = `SRLCT_CYC_NA;
                  `SRLCT_I_DIO: cycles = lat ? `SRLCT_CYC_0 : `SRLCT_CYC_4;
                  `SRLCT_I_QIO: cycles = lat ? `SRLCT_CYC_4 : `SRLCT_CYC_2;
                  default:      cycles = lat ? `SRLCT_CYC_8 : `SRLCT_CYC_0;
               endcase
            end
            `SRLCT_LC_90: begin
               case (cls)
                  `SRLCT_I_RD:  cycles = `SRLCT_CYC_NA;
                  `SRLCT_I_DIO: cycles = lat ? `SRLCT_CYC_1 : `SRLCT_CYC_4;
                  `SRLCT_I_QIO: cycles = lat ? `SRLCT_CYC_4 : `SRLCT_CYC_2;
                  default:      cycles = lat ? `SRLCT_CYC_8 : `SRLCT_CYC_0;
               endcase
            end
            default: cycles = `SRLCT_CYC_NA;
         endcase
      end
   endfunction

   // Frequency limit and latency code held by each stored row.
   function [9:0] row_head;
      input [1:0] row;
      begin
         case (row)
            2'd0:    row_head = {`SRLCT_LC_50, `SRLCT_FREQ_50};
            2'd1:    row_head = {`SRLCT_LC_80, `SRLCT_FREQ_80};
            2'd2:    row_head = {`SRLCT_LC_90, `SRLCT_FREQ_90};
            default: row_head = {`SRLCT_LC_50, `SRLCT_BLANK};
         endcase
      end
   endfunction

   // ========================================================================
   // Query byte lookup
   reg  [7:0] tbl_byte;
   reg  [6:0] tbl_rel;
   reg  [6:0] tbl_pos;
   reg  [1:0] tbl_row;
   reg  [9:0] tbl_head;
   reg  [6:0] tbl_k;

   // Rows are located by subtraction so no divider is built for the
   // fourteen-byte row pitch.
   always @* begin
      tbl_byte = `SRLCT_BLANK;
      tbl_rel  = qry_addr - `SRLCT_OFF_ROW2;
      tbl_row  = 2'd0;
      tbl_pos  = tbl_rel;
      if (tbl_rel >= `SRLCT_ROW_LEN) begin
         tbl_row = 2'd1;
         tbl_pos = tbl_rel - `SRLCT_ROW_LEN;
      end
      if (tbl_rel >= (`SRLCT_ROW_LEN + `SRLCT_ROW_LEN)) begin
         tbl_row = 2'd2;
         tbl_pos = tbl_rel - (`SRLCT_ROW_LEN + `SRLCT_ROW_LEN);
      end
      tbl_head = row_head(tbl_row);
      tbl_k    = tbl_pos - `SRLCT_POS_CYC;
      if (qry_addr == `SRLCT_OFF_ID) begin
         tbl_byte = `SRLCT_PARAM_ID;
      end else if (qry_addr == `SRLCT_OFF_LEN) begin
         tbl_byte = `SRLCT_PARAM_LEN;
      end else if (qry_addr == `SRLCT_OFF_ROWS) begin
         tbl_byte = `SRLCT_NUM_ROWS;
      end else if (qry_addr == `SRLCT_OFF_RLEN) begin
         tbl_byte = `SRLCT_ROW_BYTES;
      end else if (qry_addr == `SRLCT_OFF_HDR_F) begin
         tbl_byte = `SRLCT_HDR_F;
      end else if (qry_addr == `SRLCT_OFF_HDR_C) begin
         tbl_byte = `SRLCT_HDR_C;
      end else if (qry_addr < `SRLCT_OFF_ROW2) begin
         tbl_byte = op_of_pos(qry_addr - `SRLCT_OFF_OPS);
      end else if (tbl_rel >= (`SRLCT_ROW_LEN + `SRLCT_ROW_LEN + `SRLCT_ROW_LEN)) begin
         tbl_byte = `SRLCT_BLANK;
      end else if (tbl_pos == `SRLCT_POS_FREQ) begin
         tbl_byte = tbl_head[7:0];
      end else if (tbl_pos == `SRLCT_POS_CODE) begin
         tbl_byte = {6'h00, tbl_head[9:8]};
      end else begin
         tbl_byte = cycles(tbl_head[9:8], tbl_k[3:1], tbl_k[0]);
      end
   end

   reg        qry_valid_reg;
   reg  [7:0] qry_data_reg;

   // Query answer registered one cycle after the request.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qry_valid_reg <= 1'b0;
         qry_data_reg  <= `SRLCT_CYC_0;
      end else begin
         qry_valid_reg <= qry_req;
         if (qry_req) begin
            qry_data_reg <= tbl_byte;
         end
      end
   end

   // ========================================================================
   // Read sequencer
   reg  [1:0] state_reg;
   reg  [1:0] state_next;
   reg  [7:0] lat_hold_reg;
   reg  [7:0] load_val;
   reg        load;
   reg        mode_reg;
   reg        dummy_reg;
   reg        data_reg;
   reg        reject_reg;
   reg        reject_next;
   reg        four_reg;
   reg  [2:0] instr_reg;
   wire       cnt_last;
   wire [4:0] dec;
   wire [7:0] new_mode;
   wire [7:0] new_lat;
   wire       new_bad;

   // The latency code is sampled at the start so a mid-read change of the
   // setting cannot stretch or cut a phase already under way.
   assign dec      = decode_op(rd_opcode);
   assign new_mode = cycles(lat_code, dec[2:0], 1'b0);
   assign new_lat  = cycles(lat_code, dec[2:0], 1'b1);
   assign new_bad  = !dec[4] || (new_mode == `SRLCT_CYC_NA) ||
                     (new_lat == `SRLCT_CYC_NA);

   srlct_cyc_cnt u_cnt (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (load),
      .load_val (load_val),
      .tick     (sck_tick),
      .last     (cnt_last),
      .count    ()
   );

   // Next state; rd_stop ends any read at once, and a start while busy
   // is ignored because the frame has not ended.
   always @* begin
      state_next  = state_reg;
      load        = 1'b0;
      load_val    = `SRLCT_CYC_0;
      reject_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (rd_start && !rd_stop) begin
               if (new_bad) begin
                  reject_next = 1'b1;
               end else if (new_mode != `SRLCT_CYC_0) begin
                  state_next = ST_MODE;
                  load       = 1'b1;
                  load_val   = new_mode;
               end else if (new_lat != `SRLCT_CYC_0) begin
                  state_next = ST_LAT;
                  load       = 1'b1;
                  load_val   = new_lat;
               end else begin
                  state_next = ST_DATA;
               end
            end
         end
         ST_MODE: begin
            if (rd_stop) begin
               state_next = ST_IDLE;
            end else if (cnt_last) begin
               if (lat_hold_reg != `SRLCT_CYC_0) begin
                  state_next = ST_LAT;
                  load       = 1'b1;
                  load_val   = lat_hold_reg;
               end else begin
                  state_next = ST_DATA;
               end
            end
         end
         ST_LAT: begin
            if (rd_stop) begin
               state_next = ST_IDLE;
            end else if (cnt_last) begin
               state_next = ST_DATA;
            end
         end
         ST_DATA: begin
            if (rd_stop) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // State and registered phase outputs.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         lat_hold_reg <= `SRLCT_CYC_0;
         mode_reg     <= 1'b0;
         dummy_reg    <= 1'b0;
         data_reg     <= 1'b0;
         reject_reg   <= 1'b0;
         four_reg     <= 1'b0;
         instr_reg    <= `SRLCT_I_RD;
      end else begin
         state_reg  <= state_next;
         mode_reg   <= (state_next == ST_MODE);
         dummy_reg  <= (state_next == ST_LAT);
         data_reg   <= (state_next == ST_DATA);
         reject_reg <= reject_next;
         if (state_reg == ST_IDLE && rd_start && !rd_stop) begin
            lat_hold_reg <= new_lat;
            four_reg     <= dec[3];
            instr_reg    <= dec[2:0];
         end
      end
   end

   // ========================================================================
   // Outputs
   assign qry_valid      = qry_valid_reg;
   assign qry_data       = qry_data_reg;
   assign rd_mode_phase  = mode_reg;
   assign rd_dummy_phase = dummy_reg;
   assign rd_data_en     = data_reg;
   assign rd_reject      = reject_reg;
   assign rd_four_byte   = four_reg;
   assign rd_instr       = instr_reg;

endmodule
`default_nettype wire

// file: common/srlct_map.vh
// Purpose: Named constants for the single-data-rate read latency code table.
// Assumes: Included by its bare name from the design files under src/.
// Notes:   Definitions only; no logic lives here.
`ifndef SRLCT_MAP_VH
`define SRLCT_MAP_VH

// ==========================================================================
// Parameter header bytes
`define SRLCT_PARAM_ID   8'h90
`define SRLCT_PARAM_LEN  8'h56
`define SRLCT_NUM_ROWS   8'h06
`define SRLCT_ROW_BYTES  8'h0e
`define SRLCT_HDR_F      8'h46
`define SRLCT_HDR_C      8'h43
`define SRLCT_BLANK      8'hff

// ==========================================================================
// Relative byte offsets inside the parameter
`define SRLCT_OFF_ID     7'h00
`define SRLCT_OFF_LEN    7'h01
`define SRLCT_OFF_ROWS   7'h02
`define SRLCT_OFF_RLEN   7'h03
`define SRLCT_OFF_HDR_F  7'h04
`define SRLCT_OFF_HDR_C  7'h05
`define SRLCT_OFF_OPS    7'h06
`define SRLCT_OFF_ROW2   7'h12
`define SRLCT_ROW_LEN    7'h0e
`define SRLCT_POS_FREQ   7'h00
`define SRLCT_POS_CODE   7'h01
`define SRLCT_POS_CYC    7'h02

// ==========================================================================
// Read instruction codes, three and four address bytes
`define SRLCT_OP_RD3     8'h03
`define SRLCT_OP_RD4     8'h13
`define SRLCT_OP_FRD3    8'h0b
`define SRLCT_OP_FRD4    8'h0c
`define SRLCT_OP_DO3     8'h3b
`define SRLCT_OP_DO4     8'h3c
`define SRLCT_OP_QO3     8'h6b
`define SRLCT_OP_QO4     8'h6c
`define SRLCT_OP_DIO3    8'hbb
`define SRLCT_OP_DIO4    8'hbc
`define SRLCT_OP_QIO3    8'heb
`define SRLCT_OP_QIO4    8'hec

// Instruction class indices used by the cycle lookup.
`define SRLCT_I_RD       3'd0
`define SRLCT_I_FRD      3'd1
`define SRLCT_I_DO       3'd2
`define SRLCT_I_QO       3'd3
`define SRLCT_I_DIO      3'd4
`define SRLCT_I_QIO      3'd5

// ==========================================================================
// Frequency rows and their latency code settings
`define SRLCT_FREQ_50    8'h32
`define SRLCT_FREQ_80    8'h50
`define SRLCT_FREQ_90    8'h5a
`define SRLCT_LC_50      2'b11
`define SRLCT_LC_80      2'b00
`define SRLCT_LC_90      2'b01

// Cycle count values found in the rows.
`define SRLCT_CYC_0      8'h00
`define SRLCT_CYC_1      8'h01
`define SRLCT_CYC_2      8'h02
`define SRLCT_CYC_4      8'h04
`define SRLCT_CYC_8      8'h08
`define SRLCT_CYC_NA     8'hff
`define SRLCT_CNT_ONE    8'h01

`endif

// file: src/srlct_cyc_cnt.v
// Purpose: Down counter of serial clock cycles for the mode and latency phases.
// Assumes: tick is one clk cycle wide per serial clock cycle, same clock.
// Notes:   A load wins over a tick in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "srlct_map.vh"

module srlct_cyc_cnt (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       load,
   input  wire [7:0] load_val,
   input  wire       tick,
   output wire       last,
   output wire [7:0] count
);

   reg [7:0] cnt_reg;

   // ========================================================================
   // Counter
   // The load has priority so a new phase never inherits a stale count.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= `SRLCT_CYC_0;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (tick && (cnt_reg != `SRLCT_CYC_0)) begin
         cnt_reg <= cnt_reg - `SRLCT_CNT_ONE;
      end
   end

   // The final cycle of a phase is the tick that takes the count from one.
   assign last  = tick && (cnt_reg == `SRLCT_CNT_ONE);
   assign count = cnt_reg;

endmodule
`default_nettype wire

// file: src/dummy_never.v
`timescale 1ns/10ps

// file: verif/srlct_top_assertions.sv
// Purpose: Port checks for the latency code table block.
// Assumes: lat_code is steady through a read frame.
// Notes:   Bound to srlct_top from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module srlct_top_assertions (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       qry_req,
   input wire logic [6:0] qry_addr,
   input wire logic       qry_valid,
   input wire logic [7:0] qry_data,
   input wire logic [1:0] lat_code,
   input wire logic       rd_start,
   input wire logic [7:0] rd_opcode,
   input wire logic       sck_tick,
   input wire logic       rd_stop,
   input wire logic       rd_mode_phase,
   input wire logic       rd_dummy_phase,
   input wire logic       rd_data_en,
   input wire logic       rd_reject,
   input wire logic       rd_four_byte,
   input wire logic [2:0] rd_instr
);
   // ==========
   // Helper logic
   localparam logic [95:0] ops_tbl = 96'h03130b0c3b3c6b6cbbbcebec;
   logic       take;
   logic [7:0] lat_cnt_reg;

   // A start counts only when no phase output is up.
   assign take = rd_start && !rd_stop && !(rd_mode_phase || rd_dummy_phase || rd_data_en);

   // Latency ticks are counted so eight cycles need no long repetition.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lat_cnt_reg <= 8'h00;
      end else begin
         lat_cnt_reg <= rd_dummy_phase ? lat_cnt_reg + {7'h00, sck_tick} : 8'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ==========
   // Query table contents
   a_id_byte: assert property (
      qry_req && qry_addr == 7'h00 |=> qry_valid && qry_data == 8'h90)
      else $error("identifier byte wrong");
   a_len_byte: assert property (
      qry_req && qry_addr == 7'h01 |=> qry_valid && qry_data == 8'h56)
      else $error("length byte wrong");
   a_header_ascii: assert property (
      qry_req && qry_addr inside {7'h04, 7'h05}
      |=> qry_data == (($past(qry_addr) == 7'h04) ? 8'h46 : 8'h43))
      else $error("header column labels wrong");
   a_opcode_list: assert property (
      qry_req && qry_addr >= 7'h06 && qry_addr <= 7'h11
      |=> qry_data == ops_tbl[8 * (7'h11 - $past(qry_addr)) +: 8])
      else $error("opcode list wrong");
   a_row_50mhz: assert property (
      qry_req && qry_addr inside {7'h12, 7'h13}
      |=> qry_data == (($past(qry_addr) == 7'h12) ? 8'h32 : 8'h03))
      else $error("50 MHz row heading wrong");
   a_row_80mhz: assert property (
      qry_req && qry_addr inside {7'h20, 7'h21}
      |=> qry_data == (($past(qry_addr) == 7'h20) ? 8'h50 : 8'h00))
      else $error("80 MHz row heading wrong");
   a_row_90mhz: assert property (
      qry_req && qry_addr inside {7'h2e, 7'h2f}
      |=> qry_data == (($past(qry_addr) == 7'h2e) ? 8'h5a : 8'h01))
      else $error("90 MHz row heading wrong");

   // ==========
   // Read sequencing
   a_normal_at_80: assert property (
      take && lat_code == 2'b00 && rd_opcode inside {8'h03, 8'h13}
      |=> rd_reject && !rd_data_en && !rd_mode_phase)
      else $error("normal read not refused");
   a_plain_lat11: assert property (
      take && lat_code == 2'b11
      && rd_opcode inside {8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c}
      |=> rd_data_en && !rd_mode_phase && !rd_dummy_phase)
      else $error("plain read delayed");
   a_dual_io_mode: assert property (
      take && lat_code == 2'b11 && rd_opcode inside {8'hbb, 8'hbc}
      |=> rd_mode_phase && rd_instr == 3'd4)
      else $error("dual io mode skipped");
   a_quad_io_lat: assert property (
      rd_dummy_phase && sck_tick && !rd_stop && rd_instr == 3'd5 && lat_code == 2'b11
      |=> rd_data_en && !rd_dummy_phase)
      else $error("quad io latency not one cycle");
   a_fast_lat00: assert property (
      take && lat_code == 2'b00 && rd_opcode inside {8'h0b, 8'h0c, 8'h3b, 8'h3c}
      |=> rd_dummy_phase && !rd_mode_phase)
      else $error("fast read skipped latency");
   a_eight_latency: assert property (
      rd_dummy_phase && sck_tick && !rd_stop && lat_cnt_reg == 8'h07
      && lat_code == 2'b00 && rd_instr inside {3'd1, 3'd2}
      |=> rd_data_en && !rd_dummy_phase)
      else $error("latency not eight cycles");
   a_data_gate: assert property (
      rd_data_en && !rd_stop |=> rd_data_en && !rd_mode_phase && !rd_dummy_phase)
      else $error("data phase dropped or mixed");
   a_mode_holds: assert property (
      rd_mode_phase && !sck_tick && !rd_stop |=> rd_mode_phase)
      else $error("mode phase ended without a tick");
   a_stop_idles: assert property (
      rd_stop |=> !rd_mode_phase && !rd_dummy_phase && !rd_data_en)
      else $error("frame end left a phase up");
endmodule
`default_nettype wire

// file: verif/srlct_host_model.sv
// Purpose: Host that queries the table and frames reads.
// Assumes: Tasks start and end one time unit after a rising edge.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/10ps
`default_nettype none
module srlct_host_model (
   input  wire logic       clk,
   input  wire logic       qry_valid,
   input  wire logic [7:0] qry_data,
   output var  logic       qry_req,
   output var  logic [6:0] qry_addr,
   output var  logic [1:0] lat_code,
   output var  logic       rd_start,
   output var  logic [7:0] rd_opcode,
   output var  logic       sck_tick,
   output var  logic       rd_stop
);
   // ==========
   // Idle levels at time zero.
   initial begin
      qry_req = 1'b0;
      qry_addr = 7'h00;
      lat_code = 2'b11;
      rd_start = 1'b0;
      rd_opcode = 8'h00;
      sck_tick = 1'b0;
      rd_stop = 1'b0;
   end

   // ==========
   // The request stays up so queries may run back to back.
   task automatic query(input logic [6:0] a, output logic v, output logic [7:0] d);
      qry_req = 1'b1;
      qry_addr = a;
      @(posedge clk);
      #1;
      v = qry_valid;
      d = qry_data;
   endtask

   task automatic qrel();
      qry_req = 1'b0;
      qry_addr = ~qry_addr;
      @(posedge clk);
      #1;
   endtask

   // The next parameter sits one past the length byte plus its value.
   task automatic next_param(input logic [6:0] loc, input logic [7:0] len, output logic [6:0] nxt);
      nxt = loc + len[6:0] + 7'h01;
   endtask

   // ==========
   // Read framing; lat_code holds through the frame.
   // A normal read at 80 MHz goes out only to be refused.
   task automatic start(input logic [7:0] op, input logic [1:0] lc);
      lat_code = lc;
      rd_opcode = op;
      rd_start = 1'b1;
      @(posedge clk);
      #1;
      rd_start = 1'b0;
      rd_opcode = ~op;
   endtask

   // The tick stays up until gap or stop drops it.
   task automatic tick();
      sck_tick = 1'b1;
      @(posedge clk);
      #1;
   endtask

   task automatic gap(input int n);
      repeat (n) begin
         sck_tick = 1'b0;
         @(posedge clk);
         #1;
      end
   endtask

   task automatic stop();
      rd_stop = 1'b1;
      sck_tick = 1'b0;
      @(posedge clk);
      #1;
      rd_stop = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: verif/srlct_top_bench.sv
// Purpose: Self-checking bench for the latency code table block.
// Assumes: The host model drives every input but clock and reset.
// Notes:   Expected values come from the bench's own table copy.
`timescale 1ns/10ps
`default_nettype none
module srlct_top_bench;
   localparam logic [479:0] tbl = {48'h9056060e4643, 96'h03130b0c3b3c6b6cbbbcebec,
      112'h3203000000000000000004000201, 112'h5000ffff00080008000804000204,
      112'h5a01ffff00080008000804010204};
   logic       clk;
   logic       rst_n;
   logic       v;
   logic [7:0] d;
   logic [6:0] nx;
   int         n_fail;
   int         check_count;
   wire        qry_req, qry_valid, rd_start, sck_tick, rd_stop;
   wire  [6:0] qry_addr;
   wire  [7:0] qry_data, rd_opcode;
   wire  [1:0] lat_code;
   wire        rd_mode_phase, rd_dummy_phase, rd_data_en, rd_reject, rd_four_byte;
   wire  [2:0] rd_instr;

   // ==========
   // Design, host and clock
   srlct_top dut (.clk(clk), .rst_n(rst_n), .qry_req(qry_req), .qry_addr(qry_addr),
      .qry_valid(qry_valid), .qry_data(qry_data), .lat_code(lat_code), .rd_start(rd_start),
      .rd_opcode(rd_opcode), .sck_tick(sck_tick), .rd_stop(rd_stop),
      .rd_mode_phase(rd_mode_phase), .rd_dummy_phase(rd_dummy_phase),
      .rd_data_en(rd_data_en), .rd_reject(rd_reject), .rd_four_byte(rd_four_byte),
      .rd_instr(rd_instr));
   srlct_host_model host (.clk(clk), .qry_valid(qry_valid), .qry_data(qry_data),
      .qry_req(qry_req), .qry_addr(qry_addr), .lat_code(lat_code), .rd_start(rd_start),
      .rd_opcode(rd_opcode), .sck_tick(sck_tick), .rd_stop(rd_stop));

   // 20 MHz clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========
   // Expectations and comparisons
   function automatic logic [7:0] tb(input int a);
      return (a > 59) ? 8'hff : tbl[8 * (59 - a) +: 8];
   endfunction

   // Class and address form of an opcode; all ones if not a read.
   function automatic logic [3:0] op_info(input logic [7:0] op);
      for (int i = 0; i < 12; i++) begin
         if (tb(6 + i) === op) begin
            return {i[3:1], i[0]};
         end
      end
      return 4'hf;
   endfunction

   function automatic logic [7:0] st();
      return {rd_reject, rd_four_byte, rd_instr, rd_mode_phase, rd_dummy_phase, rd_data_en};
   endfunction

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t query byte %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_state(input logic [7:0] exp, input logic [7:0] msk);
      check_count++;
      if ((st() & msk) !== (exp & msk)) begin
         n_fail++;
         $display("[FAIL] %0t read state %h expected %h", $time, st(), exp);
      end
   endtask

   // One read frame; random gaps between ticks show that phases hold.
   task automatic run_read(input logic [7:0] op, input logic [1:0] lc, input bit abrt);
      logic [3:0] inf;
      logic [7:0] m, l;
      logic [4:0] pre;
      logic [2:0] ph;
      int         base;
      inf = op_info(op);
      base = (lc == 2'b11) ? 'h14 : ((lc == 2'b00) ? 'h22 : 'h30);
      m = tb(base + 2 * inf[3:1]);
      l = tb(base + 2 * inf[3:1] + 1);
      pre = {1'b0, inf[0], inf[3:1]};
      host.start(op, lc);
      if (inf == 4'hf || lc == 2'b10 || m == 8'hff) begin
         cmp_state(8'h80, 8'h87);
         host.gap(1);
         cmp_state(8'h00, 8'h87);
      end else if (abrt) begin
         host.stop();
         cmp_state(8'h00, 8'h07);
      end else begin
         for (int i = 0; i <= m + l; i++) begin
            ph = (i < m) ? 3'b100 : ((i < m + l) ? 3'b010 : 3'b001);
            cmp_state({pre, ph}, 8'hff);
            host.gap($urandom_range(0, 2));
            cmp_state({pre, ph}, 8'hff);
            if (i < m + l) begin
               host.tick();
            end
         end
         host.stop();
         cmp_state(8'h00, 8'h07);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========
   // Reset, whole table, random bytes, then every read under every code.
   initial begin
      rst_n = 1'b0;
      n_fail = 0;
      check_count = 0;
      void'($urandom(14366));
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      cmp_state(8'h00, 8'hff);
      for (int a = 0; a < 128; a++) begin
         host.query(a[6:0], v, d);
         cmp_byte({7'h00, v}, 8'h01);
         cmp_byte(d, tb(a));
      end
      host.qrel();
      cmp_byte({7'h00, qry_valid}, 8'h00);
      cmp_byte(qry_data, 8'hff);
      repeat (24) begin
         nx = 7'($urandom_range(0, 127));
         host.query(nx, v, d);
         host.qrel();
         cmp_byte(d, tb(nx));
      end
      host.query(7'h01, v, d);
      host.next_param(7'h01, d, nx);
      host.query(nx, v, d);
      host.qrel();
      cmp_byte(d, 8'hff);
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 12; i++) begin
            run_read(tb(6 + i), c[1:0], 1'b0);
         end
      end
      run_read(8'heb, 2'b11, 1'b1);
      run_read(8'h0b, 2'b00, 1'b1);
      repeat (8) begin
         run_read(8'($urandom_range(0, 255)), 2'($urandom_range(0, 3)), 1'b0);
      end
      tally_and_finish();
   end

   // A hang is cut short and counted as a mismatch.
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule

bind srlct_top srlct_top_assertions u_chk (.clk(clk), .rst_n(rst_n), .qry_req(qry_req),
   .qry_addr(qry_addr), .qry_valid(qry_valid), .qry_data(qry_data), .lat_code(lat_code),
   .rd_start(rd_start), .rd_opcode(rd_opcode), .sck_tick(sck_tick), .rd_stop(rd_stop),
   .rd_mode_phase(rd_mode_phase), .rd_dummy_phase(rd_dummy_phase), .rd_data_en(rd_data_en),
   .rd_reject(rd_reject), .rd_four_byte(rd_four_byte), .rd_instr(rd_instr));
`default_nettype wire
